/* File: crs_supply_clock.sv */
// Supply, reset sequencing, clock source and clock security logic with Wishbone registers
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps

module crs_supply_clock #(
  parameter int unsigned TB_PERIOD_0 = 32000,
  parameter int unsigned TB_PERIOD_1 = 64000,
  parameter int unsigned TB_PERIOD_2 = 160000,
  parameter int unsigned TB_PERIOD_3 = 400000
) (
  input wire logic clock, // System clock, 25 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic undervoltage_low, // Detector: supply below threshold
  input wire logic watchdog_underflow, // Watchdog underflow pulse
  input wire logic reset_pin_in, // Reset pin level
  output logic reset_pin_out, // Reset pin drive value
  output logic reset_pin_oe_n, // Reset pin enable, low drives
  input wire logic [2:0] osc_select, // Option byte: clock source
  input wire logic css_disable, // Option byte: security off
  input wire logic lvd_disable, // Option byte: detector off
  input wire logic main_osc_lost, // Monitor: main clock gone
  input wire logic main_osc_spike, // Monitor: main clock spiking
  input wire logic active_halt, // CPU in active-halt mode
  output logic [2:0] osc_source_sel, // Selected clock source
  output logic resonator_run, // Resonator oscillator enable
  output logic main_clk_gate, // Main clock passes the filter
  output logic safe_osc_select, // Safe oscillator in use
  output logic cpu_reset, // CPU held in reset
  output logic vector_fetch, // Reset vector fetch phase
  output logic cpu_clk_en, // CPU clock tick from prescaler
  output logic clock_out_pin, // Clock-out pin
  output logic irq // Interrupt request
);
  import crs_pkg::*;
  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic [DIV_W-1:0] div_mask(input logic slow, input logic [1:0] cp);
    logic [DIV_W-1:0] m;
    m = 5'h01;
    if (slow) begin
      case (cp)
        2'h0: m = 5'h03;
        2'h1: m = 5'h07;
        2'h2: m = 5'h0F;
        default: m = 5'h1F;
      endcase
    end
    return m;
  endfunction

  function automatic logic [TB_CNT_W-1:0] tb_last(input logic [1:0] sel);
    logic [TB_CNT_W-1:0] v;
    case (sel)
      2'h0: v = TB_CNT_W'(TB_PERIOD_0 - 1);
      2'h1: v = TB_CNT_W'(TB_PERIOD_1 - 1);
      2'h2: v = TB_CNT_W'(TB_PERIOD_2 - 1);
      default: v = TB_CNT_W'(TB_PERIOD_3 - 1);
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  assign raw_in = {osc_select, css_disable, lvd_disable, main_osc_spike, main_osc_lost,
                   reset_pin_in, undervoltage_low};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        meta_q[gi] <= raw_in[gi];
        sync_q[gi] <= meta_q[gi];
      end
    end
  endgenerate
  logic uv_s, pin_s, lost_s, spike_s, lvd_dis_s, css_dis_s;
  logic [2:0] osc_s;
  assign uv_s = sync_q[0] & ~lvd_dis_s;
  assign pin_s = sync_q[1];
  assign lost_s = sync_q[2];
  assign spike_s = sync_q[3];
  assign lvd_dis_s = sync_q[4];
  assign css_dis_s = sync_q[5];
  assign osc_s = sync_q[8:6];

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdat_q;
  logic acc, wr_acc, rd_acc;
  logic [5:0] idx;
  assign idx = wb_adr_i[7:2];
  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_acc = acc & wb_we_i & wb_sel_i[0];
  assign rd_acc = acc & ~wb_we_i;

  logic lvd_flag_q, wdg_flag_q, safe_flag_q, safe_ie_q;
  logic tb_flag_q, tb_ie_q;
  logic [1:0] tb_sel_q, cp_q;
  logic sms_q, mco_q;
  logic [7:0] status_rd;
  assign status_rd = {3'h0, lvd_flag_q, 1'b0, safe_ie_q, safe_flag_q, wdg_flag_q};

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      rdat_q <= 32'h0000_0000;
      if (rd_acc) begin
        case (idx)
          IDX_STATUS: rdat_q <= {24'h00_0000, status_rd};
          IDX_MCC: rdat_q <= {28'h000_0000, tb_sel_q, tb_ie_q, tb_flag_q};
          IDX_MISC: rdat_q <= {28'h000_0000, mco_q, sms_q, cp_q};
          default: rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ------------------------------------------------------------
  // Reset sequencer
  // ------------------------------------------------------------
  crs_rst_state_t state_q, state_d;
  crs_cause_t cause_q, cause_d;
  logic [SEQ_CNT_W-1:0] cnt_q, cnt_d;

  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    cnt_d = cnt_q + 1'b1;
    case (state_q)
      RS_DRIVE: begin
        if (!uv_s && cnt_q >= SEQ_CNT_W'(MIN_DRIVE_CYC - 1)) begin
          state_d = RS_DELAY;
          cnt_d = '0;
        end
      end
      RS_DELAY: begin
        if (cnt_q == SEQ_CNT_W'(RST_DELAY_CYC - 1)) begin
          state_d = RS_FETCH;
          cnt_d = '0;
        end
      end
      RS_FETCH: begin
        if (cnt_q == SEQ_CNT_W'(FETCH_CYC - 1)) begin
          state_d = RS_RUN;
          cnt_d = '0;
        end
      end
      RS_RUN: begin
        cnt_d = '0;
        if (watchdog_underflow) begin
          state_d = RS_DRIVE;
          cause_d = CAUSE_WDG;
        end else if (!pin_s) begin
          state_d = RS_DRIVE;
          cause_d = CAUSE_EXT;
        end
      end
      default: state_d = RS_DRIVE;
    endcase
    if (uv_s && !(state_q == RS_DRIVE && cause_q == CAUSE_LVD)) begin
      state_d = RS_DRIVE;
      cause_d = CAUSE_LVD;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= RS_DRIVE;
      cause_q <= CAUSE_EXT;
      cnt_q <= '0;
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= 1'b0;
      cpu_reset <= 1'b1;
      vector_fetch <= 1'b0;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      cnt_q <= cnt_d;
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= (state_d != RS_DRIVE);
      cpu_reset <= (state_d == RS_DRIVE) || (state_d == RS_DELAY);
      vector_fetch <= (state_d == RS_FETCH);
    end
  end

  logic enter_drive;
  assign enter_drive = (state_d == RS_DRIVE) && (state_q != RS_DRIVE || cause_d != cause_q);

  // ------------------------------------------------------------
  // Reset source flags
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      lvd_flag_q <= 1'b0;
      wdg_flag_q <= 1'b0;
      safe_ie_q <= 1'b0;
    end else begin
      if (wr_acc && idx == IDX_STATUS) begin
        safe_ie_q <= wb_dat_i[ST_IE];
        if (!wb_dat_i[ST_LVD]) lvd_flag_q <= 1'b0;
        if (!wb_dat_i[ST_WDG]) wdg_flag_q <= 1'b0;
      end
      if (enter_drive && cause_d == CAUSE_LVD) begin
        lvd_flag_q <= 1'b1;
        wdg_flag_q <= 1'b0;
      end else if (enter_drive && cause_d == CAUSE_WDG) begin
        wdg_flag_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Clock source and clock security
  // ------------------------------------------------------------
  logic css_en;
  assign css_en = ~css_dis_s;

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_source_sel <= OSC_EXT;
      resonator_run <= 1'b0;
      main_clk_gate <= 1'b1;
      safe_osc_select <= 1'b0;
      safe_flag_q <= 1'b0;
    end else begin
      osc_source_sel <= (osc_s > OSC_INT_RC) ? OSC_EXT : osc_s;
      resonator_run <= (osc_s >= OSC_RES_FIRST) && (osc_s <= OSC_RES_LAST);
      main_clk_gate <= ~(css_en & spike_s);
      safe_osc_select <= css_en & lost_s;
      if (!css_en) begin
        safe_flag_q <= 1'b0;
      end else if (safe_osc_select) begin
        safe_flag_q <= 1'b1;
      end else if (rd_acc && idx == IDX_STATUS) begin
        safe_flag_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Main clock controller: prescaler, time base, clock-out
  // ------------------------------------------------------------
  logic [DIV_W-1:0] div_q;
  logic [TB_CNT_W-1:0] tb_cnt_q;
  logic [1:0] tb_act_q;
  logic tb_end;
  assign tb_end = (tb_cnt_q == tb_last(tb_act_q));

  always_ff @(posedge clock) begin
    if (rst) begin
      cp_q <= 2'h0;
      sms_q <= 1'b0;
      mco_q <= 1'b0;
      tb_sel_q <= 2'h0;
      tb_ie_q <= 1'b0;
    end else if (wr_acc && idx == IDX_MISC) begin
      cp_q <= wb_dat_i[MS_CP +: 2];
      sms_q <= wb_dat_i[MS_SMS];
      mco_q <= wb_dat_i[MS_MCO];
    end else if (wr_acc && idx == IDX_MCC) begin
      tb_sel_q <= wb_dat_i[MC_TB +: 2];
      tb_ie_q <= wb_dat_i[MC_IE];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      div_q <= '0;
      cpu_clk_en <= 1'b0;
    end else begin
      div_q <= div_q + 1'b1;
      cpu_clk_en <= ((div_q & div_mask(sms_q, cp_q)) == div_mask(sms_q, cp_q));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tb_cnt_q <= '0;
      tb_act_q <= 2'h0;
      tb_flag_q <= MC_FLAG_RST;
    end else begin
      tb_cnt_q <= tb_end ? '0 : tb_cnt_q + 1'b1;
      if (tb_end) tb_act_q <= tb_sel_q;
      if (tb_end) begin
        tb_flag_q <= 1'b1;
      end else if (rd_acc && idx == IDX_MCC) begin
        tb_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      clock_out_pin <= 1'b0;
      irq <= 1'b0;
    end else begin
      clock_out_pin <= (mco_q && !active_halt) ? ~clock_out_pin : 1'b0;
      irq <= (safe_flag_q & safe_ie_q & css_en) | (tb_flag_q & tb_ie_q);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_uv_drives_pin: assert property (uv_s |=> !reset_pin_oe_n)
    else $error("reset pin not driven during undervoltage");
  chk_wdg_min_drive: assert property ((state_q == RS_RUN && watchdog_underflow && !uv_s)
    |=> !reset_pin_oe_n[*8])
    else $error("watchdog reset drive too short");
  chk_release_count: assert property ($rose(reset_pin_oe_n) && $past(cause_q) != CAUSE_LVD
    |-> $past(cnt_q) >= SEQ_CNT_W'(MIN_DRIVE_CYC - 1))
    else $error("reset pin released before minimum time");
  chk_default_source: assert property (osc_s == OSC_EXT |=> osc_source_sel == OSC_EXT)
    else $error("default option does not select external clock");
  chk_resonator_reset: assert property (cpu_reset && osc_s >= OSC_RES_FIRST
    && osc_s <= OSC_RES_LAST && $stable(osc_s) |-> resonator_run)
    else $error("resonator stopped during reset");
  chk_safe_flag_off: assert property (css_dis_s |=> !safe_flag_q && !safe_osc_select)
    else $error("safe flag set while security disabled");
  chk_safe_flag_hold: assert property (safe_osc_select && css_en |=> safe_flag_q)
    else $error("safe flag not held while safe clock active");
  chk_irq_gate: assert property (safe_flag_q && safe_ie_q && css_en |=> irq)
    else $error("safe clock interrupt missing");
  chk_lvd_clears_wdg: assert property (enter_drive && cause_d == CAUSE_LVD
    |=> lvd_flag_q && !wdg_flag_q)
    else $error("undervoltage reset flags wrong");
  chk_lvd_kept: assert property (enter_drive && cause_d != CAUSE_LVD && lvd_flag_q
    && !(wr_acc && idx == IDX_STATUS) |=> lvd_flag_q)
    else $error("undervoltage flag lost on later reset");
  chk_reserved_zero: assert property ($past(rd_acc && idx == IDX_STATUS)
    |-> {rdat_q[7:5], rdat_q[3]} == 4'h0)
    else $error("reserved bits read nonzero");
  chk_delay_length: assert property ($rose(vector_fetch) |-> $past(cnt_q) == 13'h0FFF)
    else $error("internal reset delay not 4096 cycles");
  chk_fetch_two: assert property ($rose(vector_fetch) |-> vector_fetch ##1 vector_fetch
    ##1 !vector_fetch)
    else $error("vector fetch not two cycles");
  chk_clock_out_halt: assert property (active_halt |=> !clock_out_pin)
    else $error("clock-out runs in active-halt");
endmodule // crs_supply_clock

/* File: crs_pkg.sv */
// Constants, register map and types for the supply, reset and clock security block
package crs_pkg;
  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned MIN_DRIVE_NS = 1500;
  localparam int unsigned MIN_DRIVE_CYC = (MIN_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_DELAY_CYC = 4096;
  localparam int unsigned FETCH_CYC = 2;
  localparam int unsigned SEQ_CNT_W = 13;
  localparam int unsigned TB_CNT_W = 19;
  localparam int unsigned DIV_W = 5;
  localparam int unsigned SYNC_W = 9;
  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_MCC = 6'h29;
  localparam logic [5:0] IDX_STATUS = 6'h2B;
  localparam logic [5:0] IDX_MISC = 6'h2C;
  // Status register fields
  localparam int unsigned ST_WDG = 0;
  localparam int unsigned ST_SAFE = 1;
  localparam int unsigned ST_IE = 2;
  localparam int unsigned ST_LVD = 4;
  // Main clock control/status fields
  localparam int unsigned MC_FLAG = 0;
  localparam int unsigned MC_IE = 1;
  localparam int unsigned MC_TB = 2;
  localparam logic MC_FLAG_RST = 1'b1;
  // Misc control fields
  localparam int unsigned MS_CP = 0;
  localparam int unsigned MS_SMS = 2;
  localparam int unsigned MS_MCO = 3;
  // ------------------------------------------------------------
  // Oscillator source codes from the option byte
  // ------------------------------------------------------------
  localparam logic [2:0] OSC_EXT = 3'h0;
  localparam logic [2:0] OSC_RES_FIRST = 3'h1;
  localparam logic [2:0] OSC_RES_LAST = 3'h4;
  localparam logic [2:0] OSC_EXT_RC = 3'h5;
  localparam logic [2:0] OSC_INT_RC = 3'h6;
  // Reset sequencer states and reset causes
  typedef enum logic [1:0] {RS_DRIVE, RS_DELAY, RS_FETCH, RS_RUN} crs_rst_state_t;
  typedef enum logic [1:0] {CAUSE_EXT, CAUSE_WDG, CAUSE_LVD} crs_cause_t;
endpackage : crs_pkg

/* File: crs_ext_model.sv */
// Model of the supply monitor, oscillator and reset circuitry outside the block
`timescale 1ns/10ps
module crs_ext_model (
  input wire logic clock, // System clock
  input wire logic ext_low_cmd, // Bench: pull reset pin low
  input wire logic uv_cmd, // Bench: supply below threshold
  input wire logic lost_cmd, // Bench: main clock gone
  input wire logic spike_cmd, // Bench: spikes on main clock
  input wire logic reset_pin_out, // Device pin value
  input wire logic reset_pin_oe_n, // Device pin enable, low drives
  input wire logic [2:0] osc_source_sel, // Selected source
  input wire logic resonator_run, // Resonator enable
  output logic reset_pin_in, // Resolved pin level
  output logic undervoltage_low, // Supply monitor level
  output logic main_osc_lost, // Clock monitor: lost
  output logic main_osc_spike // Clock monitor: spikes
);
  // ------------------------------------------------------------
  // Pin and monitor behaviour
  // ------------------------------------------------------------
  logic res_sel;
  // Open-drain pin with pull-up: low when either side pulls it
  assign reset_pin_in = ~(ext_low_cmd | (~reset_pin_oe_n & ~reset_pin_out));
  assign res_sel = (osc_source_sel >= 3'h1) && (osc_source_sel <= 3'h4);
  // A resonator that is stopped looks like a lost clock
  assign main_osc_lost = lost_cmd | (res_sel & ~resonator_run);
  always_ff @(posedge clock) begin
    undervoltage_low <= uv_cmd;
    main_osc_spike <= spike_cmd;
  end
endmodule // crs_ext_model

/* File: test_crs_supply_clock.sv */
// Self-checking bench for the supply, reset and clock security block
`timescale 1ns/10ps
module test_crs_supply_clock;
  import crs_pkg::*;
  localparam logic [7:0] ADR_ST = 8'hAC;
  localparam logic [7:0] ADR_TB = 8'hA4;
  localparam logic [7:0] ADR_MISC = 8'hB0;
  logic clock = 1'b0, rst = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hF;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic watchdog_underflow = 1'b0, css_disable = 1'b0, active_halt = 1'b0;
  logic [2:0] osc_select = 3'h0, osc_source_sel;
  logic ext_low = 1'b0, uv = 1'b0, lost = 1'b0, spike = 1'b0;
  logic reset_pin_in, reset_pin_out, reset_pin_oe_n, undervoltage_low, main_osc_lost;
  logic main_osc_spike, resonator_run, main_clk_gate, safe_osc_select, cpu_reset;
  logic vector_fetch, cpu_clk_en, clock_out_pin, irq, prev;
  logic [7:0] rd, d;
  logic [31:0] r;
  integer seed = 32'h08d6;
  int errors = 0, check_count = 0, m_wdg = 0, m_uvf = 0, m_ie = 0, i, n;
  int drive_run = 0, drive_len = 0;

  crs_supply_clock #(.TB_PERIOD_0(8), .TB_PERIOD_1(12), .TB_PERIOD_2(16), .TB_PERIOD_3(20)) DUT (
    .clock(clock), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .undervoltage_low(undervoltage_low),
    .watchdog_underflow(watchdog_underflow), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n), .osc_select(osc_select),
    .css_disable(css_disable), .lvd_disable(1'b0), .main_osc_lost(main_osc_lost),
    .main_osc_spike(main_osc_spike), .active_halt(active_halt), .osc_source_sel(osc_source_sel),
    .resonator_run(resonator_run), .main_clk_gate(main_clk_gate),
    .safe_osc_select(safe_osc_select), .cpu_reset(cpu_reset), .vector_fetch(vector_fetch),
    .cpu_clk_en(cpu_clk_en), .clock_out_pin(clock_out_pin), .irq(irq));
  crs_ext_model far_side (
    .clock(clock), .ext_low_cmd(ext_low), .uv_cmd(uv), .lost_cmd(lost), .spike_cmd(spike),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
    .osc_source_sel(osc_source_sel), .resonator_run(resonator_run), .reset_pin_in(reset_pin_in),
    .undervoltage_low(undervoltage_low), .main_osc_lost(main_osc_lost),
    .main_osc_spike(main_osc_spike));

  // Length of the latest stretch in which the device drove the reset pin
  always @(negedge clock) begin
    if (reset_pin_oe_n === 1'b0) drive_run <= drive_run + 1;
    else if (drive_run != 0) begin
      drive_len <= drive_run;
      drive_run <= 0;
    end
  end

  // ------------------------------------------------------------
  // Compare, bus and sequence helpers
  // ------------------------------------------------------------
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check1(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  function automatic logic [7:0] m_status(input logic safe);
    return {3'h0, m_uvf[0], 1'b0, m_ie[0], safe, m_wdg[0]};
  endfunction
  task automatic wb(input logic [7:0] adr, input logic we, input logic [7:0] dat);
    @(posedge clock);
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= {24'h0, dat};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic st_rd(input logic [7:0] exp);
    wb(ADR_ST, 1'b0, 8'h00);
    check8("status", exp, rd);
  endtask
  task automatic seq_check(input logic res_exp);
    int lo, dly, vf, k;
    lo = 0;
    dly = 0;
    vf = 0;
    k = 0;
    while (reset_pin_oe_n !== 1'b0 && k < 20) begin
      @(negedge clock);
      k++;
    end
    while (reset_pin_oe_n === 1'b0 && lo < 9000) begin
      if (lo == 10) check1("res_run", res_exp, resonator_run);
      if (lo == 10) check1("pin_out", 1'b0, reset_pin_out);
      @(negedge clock);
      lo++;
    end
    while (cpu_reset === 1'b1 && vector_fetch !== 1'b1 && dly < 5000) begin
      @(negedge clock);
      dly++;
    end
    while (vector_fetch === 1'b1 && vf < 10) begin
      @(negedge clock);
      vf++;
    end
    check1("drive_min", 1'b1, drive_len >= MIN_DRIVE_CYC);
    check1("delay_len", 1'b1, dly == RST_DELAY_CYC);
    check8("fetch_len", FETCH_CYC[7:0], vf[7:0]);
    check1("cpu_run", 1'b0, cpu_reset);
  endtask
  task automatic do_reset(input int kind);
    int len;
    len = 4 + ($unsigned($random(seed)) % 8);
    @(posedge clock);
    if (kind == 1) begin
      watchdog_underflow <= 1'b1;
      @(posedge clock);
      watchdog_underflow <= 1'b0;
    end else begin
      ext_low <= (kind == 0);
      uv <= (kind == 2);
      repeat (4) @(posedge clock);
      repeat (len) begin
        @(negedge clock);
        if (kind == 2) check1("uv_drive", 1'b0, reset_pin_oe_n);
      end
      @(posedge clock);
      ext_low <= 1'b0;
      uv <= 1'b0;
    end
    seq_check(1'b1);
    if (kind == 1) m_wdg = 1;
    if (kind == 2) begin
      m_uvf = 1;
      m_wdg = 0;
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (80000) @(posedge clock);
    errors++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    seq_check(1'b0);
    st_rd(8'h00);
    check8("src_default", 8'h00, {5'h00, osc_source_sel});
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      osc_select <= i[2:0];
      repeat (6) @(negedge clock);
      check8("src_sel", (i == 7) ? 8'h00 : i[7:0], {5'h00, osc_source_sel});
      check1("res_sel", (i >= 1 && i <= 4), resonator_run);
    end
    @(posedge clock);
    osc_select <= 3'h2;
    repeat (6) @(posedge clock);
    do_reset(1);
    st_rd(m_status(1'b0));
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      d = (i == 0) ? 8'hFF : r[7:0];
      wb(ADR_ST, 1'b1, d);
      m_ie = d[2];
      m_wdg = m_wdg & d[0];
      m_uvf = m_uvf & d[4];
      st_rd(m_status(1'b0));
    end
    wb(8'hFC, 1'b0, 8'h00);
    check8("unmapped", 8'h00, rd);
    wb(ADR_ST, 1'b1, 8'h00);
    m_wdg = 0;
    m_uvf = 0;
    m_ie = 0;
    do_reset(1);
    do_reset(2);
    st_rd(m_status(1'b0));
    do_reset(1);
    st_rd(m_status(1'b0));
    wb(ADR_ST, 1'b1, 8'h10);
    m_wdg = 0;
    do_reset(0);
    st_rd(m_status(1'b0));
    wb(ADR_ST, 1'b1, 8'h00);
    m_uvf = 0;
    do_reset(0);
    st_rd(m_status(1'b0));
    wb(ADR_ST, 1'b1, 8'h04);
    m_ie = 1;
    spike <= 1'b1;
    repeat (5) @(negedge clock);
    check1("clk_gate", 1'b0, main_clk_gate);
    @(posedge clock);
    spike <= 1'b0;
    lost <= 1'b1;
    repeat (6) @(negedge clock);
    check1("clk_gate", 1'b1, main_clk_gate);
    check1("safe_sel", 1'b1, safe_osc_select);
    check1("irq", 1'b1, irq);
    st_rd(m_status(1'b1));
    st_rd(m_status(1'b1));
    lost <= 1'b0;
    repeat (5) @(negedge clock);
    check1("safe_sel", 1'b0, safe_osc_select);
    st_rd(m_status(1'b1));
    st_rd(m_status(1'b0));
    check1("irq", 1'b0, irq);
    @(posedge clock);
    css_disable <= 1'b1;
    lost <= 1'b1;
    spike <= 1'b1;
    repeat (6) @(negedge clock);
    check1("safe_off", 1'b0, safe_osc_select);
    check1("gate_off", 1'b1, main_clk_gate);
    check1("irq_off", 1'b0, irq);
    st_rd(m_status(1'b0));
    wb(ADR_MISC, 1'b1, 8'h08);
    repeat (4) @(negedge clock);
    for (i = 0; i < 6; i++) begin
      prev = clock_out_pin;
      @(negedge clock);
      check1("clk_out", ~prev, clock_out_pin);
    end
    @(posedge clock);
    active_halt <= 1'b1;
    repeat (4) @(negedge clock);
    check1("clk_out_halt", 1'b0, clock_out_pin);
    @(posedge clock);
    active_halt <= 1'b0;
    for (i = 0; i < 5; i++) begin
      wb(ADR_MISC, 1'b1, (i == 0) ? 8'h00 : (8'h04 | 8'(i - 1)));
      n = 0;
      repeat (40) @(negedge clock);
      repeat (64) begin
        @(negedge clock);
        if (cpu_clk_en === 1'b1) n++;
      end
      check8("cpu_ticks", (i == 0) ? 8'd32 : 8'(64 / (4 << (i - 1))), n[7:0]);
    end
    wb(ADR_TB, 1'b1, 8'h02);
    wb(ADR_TB, 1'b0, 8'h00);
    check8("tb_reg", 8'h03, rd);
    @(negedge clock);
    // A read that meets a period end leaves the flag set; read once more
    if (irq === 1'b1) begin
      wb(ADR_TB, 1'b0, 8'h00);
      @(negedge clock);
    end
    check1("tb_irq_clr", 1'b0, irq);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    check1("tb_irq", 1'b1, n <= 8);
    test_done();
  end
endmodule // test_crs_supply_clock
